// ==== pkg/frontend_settings_defs.svh ====
`ifndef FRONTEND_SETTINGS_DEFS_SVH
`define FRONTEND_SETTINGS_DEFS_SVH

// register offsets
`define FSS_ADDR_SETTINGS   8'h00
`define FSS_ADDR_STATUS     8'h04

// field positions in the settings word
`define FSS_BIT_CAL_TRIGGER 8
`define FSS_BIT_RATE_HI     6
`define FSS_BIT_RATE_LO     5
`define FSS_BIT_CIPHER      1
`define FSS_BIT_ENTRY_HALT  0

// reset values
`define FSS_RESET_SETTINGS  32'h0000_0000
`define FSS_RESET_STATUS    32'h0000_0000

// timing: carrier burst length during calibration
`define FSS_CAL_BURST_NS    2000
`define FSS_CLK_PERIOD_NS   5
`define FSS_CAL_BURST_CYC   ((`FSS_CAL_BURST_NS + `FSS_CLK_PERIOD_NS - 1) / `FSS_CLK_PERIOD_NS)

// per-rate dependent values: bit period in carrier cycles
`define FSS_BITLEN_26K      16'h0200
`define FSS_BITLEN_53K      16'h0100
`define FSS_BITLEN_106K     16'h0080
`define FSS_BITLEN_212K     16'h0040

`endif

// ==== pkg/frontend_settings_pkg.sv ====
package frontend_settings_pkg;

    // vicinity-card data rates
    typedef enum logic [1:0] {
        RATE_BASIC = 2'h0,
        RATE_53K   = 2'h1,
        RATE_106K  = 2'h2,
        RATE_212K  = 2'h3
    } vicinity_rate_t;

    // calibration sequencer states, gray along idle-burst-done
    typedef enum logic [1:0] {
        CAL_IDLE  = 2'b00,
        CAL_BURST = 2'b01,
        CAL_DONE  = 2'b11
    } cal_state_t;

endpackage

// ==== src/overlap_cal_seq.sv ====
`timescale 1ns/100ps
`include "frontend_settings_defs.svh"

// one-shot non-overlap calibration with a short carrier burst
module overlap_cal_seq #(
    parameter int BURST_CYC = `FSS_CAL_BURST_CYC  // burst length in clocks
) (
    input  wire logic ref_clk,     // system clock
    input  wire logic sys_rst,     // async reset, high
    input  wire logic start,       // one-cycle start request
    output logic      busy,        // calibration running
    output logic      rf_on,       // carrier forced on
    output logic      done         // one-cycle completion pulse
);
    localparam int CW = $clog2(BURST_CYC + 1);

    frontend_settings_pkg::cal_state_t state;       // current state
    frontend_settings_pkg::cal_state_t next_state;  // next state
    logic [CW-1:0]                     count;       // burst counter
    logic [CW-1:0]                     next_count;  // next counter

    // next-state logic
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            frontend_settings_pkg::CAL_IDLE: begin
                // start the burst
                if (start) begin
                    next_state = frontend_settings_pkg::CAL_BURST;
                    next_count = CW'(BURST_CYC - 1);
                end
            end
            frontend_settings_pkg::CAL_BURST: begin
                // count the burst down
                if (count == '0) begin
                    next_state = frontend_settings_pkg::CAL_DONE;
                end else begin
                    next_count = count - 1'b1;
                end
            end
            frontend_settings_pkg::CAL_DONE: begin
                next_state = frontend_settings_pkg::CAL_IDLE;
            end
            default: begin
                next_state = frontend_settings_pkg::CAL_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= frontend_settings_pkg::CAL_IDLE;
            count <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // decoded outputs
    assign busy  = (state != frontend_settings_pkg::CAL_IDLE);
    assign rf_on = (state == frontend_settings_pkg::CAL_BURST);
    assign done  = (state == frontend_settings_pkg::CAL_DONE);

endmodule

// ==== src/contactless_system_settings.sv ====
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`include "frontend_settings_defs.svh"

module contactless_system_settings #(
    parameter int BURST_CYC = `FSS_CAL_BURST_CYC  // calibration burst clocks
) (
    input  wire logic        ref_clk,          // 200 MHz system clock
    input  wire logic        sys_rst,          // async reset, high
    input  wire logic [7:0]  reg_addr,         // register byte address
    input  wire logic [31:0] reg_wdata,        // write data
    input  wire logic        reg_wr,           // write strobe
    input  wire logic        reg_rd,           // read strobe
    output logic      [31:0] reg_rdata,        // read data, one cycle later
    output logic      [1:0]  vicinity_rate,    // active vicinity rate code
    output logic      [15:0] vicinity_bitlen,  // dependent bit period value
    output logic             rate_reload,      // dependent set reloaded pulse
    output logic             cipher_stream_en, // cipher bit generation on
    output logic             entry_halt,       // anticollision starts in halt
    output logic             cal_rf_on,        // carrier on for calibration
    output logic             cal_busy          // calibration running
);
    logic [31:0] settings;        // stored settings word
    logic [31:0] next_settings;   // next settings word
    logic [31:0] next_rdata;      // next read data
    logic [15:0] next_bitlen;     // next dependent bit period
    logic        next_reload;     // next reload pulse
    logic        cal_start;       // one-cycle calibration start
    logic        cal_pending;     // trigger seen while calibration busy
    logic        next_pending;    // next pending flag
    logic        seq_busy;        // sequencer busy
    logic        seq_rf_on;       // sequencer carrier request
    logic        seq_done;        // sequencer done pulse
    logic        wr_settings;     // write to settings word
    logic        trig_write;      // trigger written as one

    // bit period lookup for each rate code
    function automatic logic [15:0] rate_bitlen(input logic [1:0] code);
        case (code)
            frontend_settings_pkg::RATE_53K:  rate_bitlen = `FSS_BITLEN_53K;
            frontend_settings_pkg::RATE_106K: rate_bitlen = `FSS_BITLEN_106K;
            frontend_settings_pkg::RATE_212K: rate_bitlen = `FSS_BITLEN_212K;
            default:                          rate_bitlen = `FSS_BITLEN_26K;
        endcase
    endfunction

    assign wr_settings = reg_wr && (reg_addr == `FSS_ADDR_SETTINGS);
    assign trig_write  = wr_settings && reg_wdata[`FSS_BIT_CAL_TRIGGER];

    // settings, dependent values and read mux
    always_comb begin
        next_settings = settings;
        next_bitlen   = vicinity_bitlen;
        next_reload   = 1'b0;
        next_rdata    = 32'h0000_0000;
        next_pending  = cal_pending;
        cal_start     = 1'b0;
        if (wr_settings) begin
            // trigger bit self-clears; other fields store
            next_settings = reg_wdata;
            next_settings[`FSS_BIT_CAL_TRIGGER] = 1'b0;
            if (reg_wdata[`FSS_BIT_RATE_HI:`FSS_BIT_RATE_LO] !=
                settings[`FSS_BIT_RATE_HI:`FSS_BIT_RATE_LO]) begin
                next_bitlen = rate_bitlen(reg_wdata[`FSS_BIT_RATE_HI:`FSS_BIT_RATE_LO]);
                next_reload = 1'b1;
            end
        end
        if (!seq_busy && (trig_write || cal_pending)) begin
            cal_start    = 1'b1;
            // a fresh trigger beside a pending one waits; set wins
            next_pending = trig_write && cal_pending;
        end else if (trig_write) begin
            // remember a trigger during a run
            next_pending = 1'b1;
        end
        if (reg_rd) begin
            // register reads
            case (reg_addr)
                `FSS_ADDR_SETTINGS: next_rdata = settings;
                `FSS_ADDR_STATUS:   next_rdata = {30'h0000_0000, cal_pending, seq_busy};
                default:            next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            settings        <= `FSS_RESET_SETTINGS;
            vicinity_bitlen <= `FSS_BITLEN_26K;
            rate_reload     <= 1'b0;
            reg_rdata       <= 32'h0000_0000;
            cal_pending     <= 1'b0;
            cal_rf_on       <= 1'b0;
            cal_busy        <= 1'b0;
        end else begin
            settings        <= next_settings;
            vicinity_bitlen <= next_bitlen;
            rate_reload     <= next_reload;
            reg_rdata       <= next_rdata;
            cal_pending     <= next_pending;
            cal_rf_on       <= seq_rf_on;
            cal_busy        <= seq_busy;
        end
    end

    // field outputs from flops; reset gives code 0 basic rate
    // rate code straight from the field
    assign vicinity_rate    = settings[`FSS_BIT_RATE_HI:`FSS_BIT_RATE_LO];
    assign cipher_stream_en = settings[`FSS_BIT_CIPHER];
    assign entry_halt       = settings[`FSS_BIT_ENTRY_HALT];

    // calibration sequencer
    overlap_cal_seq #(
        .BURST_CYC (BURST_CYC)
    ) u_cal (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .start   (cal_start),
        .busy    (seq_busy),
        .rf_on   (seq_rf_on),
        .done    (seq_done)
    );

    chk_cal_one_burst: assert property (
        @(posedge ref_clk) disable iff (sys_rst) cal_start |-> ##2 cal_rf_on)
        else $error("calibration burst missing");
    chk_burst_then_done: assert property (
        @(posedge ref_clk) disable iff (sys_rst) seq_done |-> !seq_rf_on ##1 !cal_rf_on)
        else $error("burst overlaps done");
    // basic rate code keeps basic period
    chk_reset_rate: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        vicinity_rate == 2'h0 |-> vicinity_bitlen == `FSS_BITLEN_26K)
        else $error("basic rate lost");
    chk_rate_map: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        rate_reload |-> vicinity_bitlen == rate_bitlen(vicinity_rate))
        else $error("bad rate map");
    chk_rate_retune: assert property (
        @(posedge ref_clk) disable iff (sys_rst) $changed(vicinity_rate) |-> rate_reload)
        else $error("no retune on rate change");
    chk_cipher_bit: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        wr_settings |=> cipher_stream_en == $past(reg_wdata[`FSS_BIT_CIPHER]))
        else $error("cipher bit");
    chk_entry_state: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        wr_settings |=> entry_halt == $past(reg_wdata[`FSS_BIT_ENTRY_HALT]))
        else $error("entry bit");
    chk_zero_no_cal: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_settings && !trig_write && !cal_pending && !seq_busy) |-> !cal_start)
        else $error("spurious cal");
    chk_single_start: assert property (
        @(posedge ref_clk) disable iff (sys_rst) cal_start |=> !cal_start)
        else $error("double calibration start");
    // trigger beside a pending one kept
    chk_pending_kept: assert property (
        @(posedge ref_clk) disable iff (sys_rst) (trig_write && cal_pending) |=> cal_pending)
        else $error("trigger lost");

endmodule

// ==== verification/contactless_system_settings_tb_top.sv ====
`timescale 1ns/100ps
module contactless_system_settings_tb_top;
    localparam int BURST = 4;                   // shortened burst length
    logic        ref_clk   = 1'b0;              // system clock
    logic        sys_rst   = 1'b1;              // reset, high
    logic [7:0]  reg_addr  = 8'h00;             // bus address
    logic [31:0] reg_wdata = 32'h0000_0000;     // bus write data
    logic        reg_wr    = 1'b0;              // write strobe
    logic        reg_rd    = 1'b0;              // read strobe
    logic [31:0] reg_rdata;                     // read data
    logic [1:0]  vicinity_rate;                 // active rate code
    logic [15:0] vicinity_bitlen;               // dependent bit period
    logic        rate_reload;                   // reload pulse
    logic        cipher_stream_en;              // cipher generation
    logic        entry_halt;                    // halt entry
    logic        cal_rf_on;                     // calibration carrier
    logic        cal_busy;                      // calibration running
    int          num_errors = 0;                // mismatches
    int          num_checks = 0;                // comparisons
    int          rf_cnt     = 0;                // carrier-on cycles seen
    int          rl_cnt     = 0;                // reload pulses seen
    int          seed       = 32'h8df5;         // fixed random seed
    int          b;                             // counter baseline
    logic [31:0] rd;                            // read result
    logic [31:0] val;                           // written word
    logic [1:0]  prev;                          // previous rate code

    contactless_system_settings #(.BURST_CYC(BURST)) uut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .vicinity_rate(vicinity_rate),
        .vicinity_bitlen(vicinity_bitlen), .rate_reload(rate_reload),
        .cipher_stream_en(cipher_stream_en), .entry_halt(entry_halt),
        .cal_rf_on(cal_rf_on), .cal_busy(cal_busy));

    // free-running 200 MHz clock
    initial forever #2.5 ref_clk = ~ref_clk;

    // counts carrier cycles and reload pulses
    always @(posedge ref_clk) begin
        if (cal_rf_on === 1'b1) rf_cnt++;
        if (rate_reload === 1'b1) rl_cnt++;
    end

    // expected bit period per rate code
    function automatic logic [15:0] bitlen_of(input logic [1:0] c);
        case (c)
            2'h1:    return 16'h0100;
            2'h2:    return 16'h0080;
            2'h3:    return 16'h0040;
            default: return 16'h0200;
        endcase
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // one-cycle write, then one edge for outputs to follow
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    // one-cycle read, data taken in the following cycle
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wait_idle;
        int i;
        for (i = 0; i < 50 && cal_busy !== 1'b0; i++) begin
            @(posedge ref_clk);
            #1;
        end
        #1;
        if (i == 50) begin
            num_errors++;
            print_verdict();
        end
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1;
        check("bitlen", vicinity_bitlen, 16'h0200);
        check("rate", vicinity_rate, 2'h0);
        bus_rd(8'h00, rd);
        check("settings", rd, 32'h0000_0000);
        $display("test reset done");
        prev = 2'h0;
        for (int c = 1; c <= 4; c++) begin
            val = (c % 4) << 5;
            b = rl_cnt;
            bus_wr(8'h00, val);
            repeat (2) @(posedge ref_clk);
            #1;
            check("rate", vicinity_rate, c % 4);
            check("bitlen", vicinity_bitlen, bitlen_of(c % 4));
            check("reload", rl_cnt - b, (c % 4) != prev);
            bus_rd(8'h00, rd);
            check("readback", rd & 32'h0000_0063, val);
            prev = c % 4;
        end
        $display("test rates done");
        for (int k = 0; k < 8; k++) begin
            val = $random(seed) & 32'h0000_0063;
            bus_wr(8'h00, val);
            #10;
            check("cipher", cipher_stream_en, val[1]);
            check("entry", entry_halt, val[0]);
            check("bitlen", vicinity_bitlen, bitlen_of(val[6:5]));
        end
        $display("test random fields done");
        // no power settings here, trigger is the last write
        b = rf_cnt;
        bus_wr(8'h00, 32'h0000_0103);
        check("busy out", cal_busy, 1'b1);
        bus_rd(8'h04, rd);
        check("busy", rd[0], 1'b1);
        wait_idle();
        check("burst", rf_cnt - b, BURST);
        bus_rd(8'h00, rd);
        check("trigger", rd[8], 1'b0);
        b = rf_cnt;
        bus_wr(8'h00, 32'h0000_0003);
        repeat (10) @(posedge ref_clk);
        #1;
        check("zero write", rf_cnt - b, 0);
        b = rf_cnt;
        // third trigger lands as the pending one launches
        repeat (3) bus_wr(8'h00, 32'h0000_0100);
        repeat (2) begin
            wait_idle();
            repeat (3) @(posedge ref_clk);
        end
        wait_idle();
        check("three runs", rf_cnt - b, 3 * BURST);
        $display("test calibration done");
        bus_wr(8'h04, 32'hffff_ffff);
        bus_rd(8'h04, rd);
        check("status", rd, 32'h0000_0000);
        bus_rd(8'h00, rd);
        check("settings kept", rd, 32'h0000_0000);
        bus_rd(8'h10, rd);
        check("unmapped", rd, 32'h0000_0000);
        $display("test refused done");
        print_verdict();
    end
endmodule
